// >>> core/epv_core.sv
`timescale 1ns/10ps
`default_nettype none
module epv_core (
  input  wire logic                          clock_in,
  input  wire logic                          reset_in,
  input  wire logic [epv_pkg::NUM_EXC-1:0]   source_in,
  input  wire logic                          take_in,
  input  wire logic                          return_in,
  input  wire logic [epv_pkg::NUM_W-1:0]     return_num_in,
  input  wire logic                          prio_wr_in,
  input  wire logic [epv_pkg::NUM_W-1:0]     prio_num_in,
  input  wire logic [epv_pkg::PRIO_W-1:0]    prio_val_in,
  input  wire logic                          enable_wr_in,
  input  wire logic [epv_pkg::NUM_W-1:0]     enable_num_in,
  input  wire logic                          enable_val_in,
  input  wire logic                          base_wr_in,
  input  wire logic [31:0]                   base_val_in,
  output var epv_pkg::epv_req_type           request_out,
  output logic      [31:0]                   vector_base_out,
  output logic      [31:0]                   stack_addr_out,
  output logic      [31:0]                   reset_vec_addr_out,
  output logic      [epv_pkg::NUM_EXC-1:0]   pending_out,
  output logic      [epv_pkg::NUM_EXC-1:0]   active_out,
  output logic      [epv_pkg::RANK_W-1:0]    running_rank_out
);

  logic [epv_pkg::NUM_EXC-1:0]                      line_sync;
  logic [epv_pkg::NUM_EXC-1:0]                      line_prev_r;
  logic [epv_pkg::NUM_EXC-1:0]                      line_rise;

  logic [epv_pkg::NUM_EXC-1:0]                      pend_r;
  logic [epv_pkg::NUM_EXC-1:0]                      pend_nxt;
  logic [epv_pkg::NUM_EXC-1:0]                      act_r;
  logic [epv_pkg::NUM_EXC-1:0]                      act_nxt;
  logic [epv_pkg::NUM_EXC-1:0]                      take_hit;
  logic [epv_pkg::NUM_EXC-1:0]                      ret_hit;

  logic [epv_pkg::NUM_EXC-1:0]                      enable_r;
  logic [epv_pkg::NUM_EXC-1:0]                      enable_nxt;
  logic [epv_pkg::NUM_EXC-1:0]                      enable_eff;
  logic [epv_pkg::PRIO_W-1:0]                       prio_r   [epv_pkg::NUM_EXC];
  logic [epv_pkg::PRIO_W-1:0]                       prio_nxt [epv_pkg::NUM_EXC];
  logic [epv_pkg::NUM_EXC-1:0][epv_pkg::RANK_W-1:0] rank;

  logic [31:0]                                      base_r;
  logic [31:0]                                      base_nxt;
  logic                                             base_ok;

  logic                                             win_found;
  logic [epv_pkg::NUM_W-1:0]                        win_num;
  logic [epv_pkg::RANK_W-1:0]                       win_rank;
  logic                                             run_found;
  logic [epv_pkg::NUM_W-1:0]                        run_num;
  logic [epv_pkg::RANK_W-1:0]                       run_rank;
  logic                                             offer;
  logic                                             take_ok;

  epv_pkg::epv_state_type                           state_r;
  epv_pkg::epv_state_type                           state_nxt;
  epv_pkg::epv_req_type                             req_r;
  epv_pkg::epv_req_type                             req_nxt;

  // Source lines come from other clock domains
  epv_sync u_sync (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in (source_in),
    .sync_out (line_sync)
  );

  // Edge detect: a held line pends once, not every cycle
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      line_prev_r <= '0;
    end else begin
      line_prev_r <= line_sync;
    end
  end

  // Reserved vectors never pend
  assign line_rise = line_sync & ~line_prev_r & epv_pkg::VALID_MASK;

  // Configuration: priorities, enables, table base
  always_comb begin
    enable_nxt = enable_r;
    for (int i = 0; i < epv_pkg::NUM_EXC; i++) begin
      prio_nxt[i] = prio_r[i];
    end
    // Fixed-priority vectors ignore priority writes
    if (prio_wr_in && epv_pkg::VALID_MASK[prio_num_in] && !epv_pkg::FIXED_MASK[prio_num_in]) begin
      prio_nxt[prio_num_in] = prio_val_in;
    end
    if (enable_wr_in && epv_pkg::VALID_MASK[enable_num_in]) begin
      enable_nxt[enable_num_in] = enable_val_in;
    end
  end

  // Out-of-range or misaligned base writes are dropped, not clipped
  assign base_ok = ((base_val_in & epv_pkg::BASE_ALIGN) == '0)
                   && (base_val_in >= epv_pkg::BASE_MIN)
                   && (base_val_in <= epv_pkg::BASE_MAX);

  always_comb begin
    base_nxt = base_r;
    if (base_wr_in && base_ok) begin
      base_nxt = base_val_in;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      enable_r <= epv_pkg::ENABLE_RESET;
      base_r   <= epv_pkg::BASE_RESET;
      for (int i = 0; i < epv_pkg::NUM_EXC; i++) begin
        prio_r[i] <= epv_pkg::PRIO_RESET;
      end
    end else begin
      enable_r <= enable_nxt;
      base_r   <= base_nxt;
      for (int i = 0; i < epv_pkg::NUM_EXC; i++) begin
        prio_r[i] <= prio_nxt[i];
      end
    end
  end

  // NMI and hard fault cannot be disabled
  assign enable_eff = (enable_r | epv_pkg::FIXED_MASK) & epv_pkg::VALID_MASK;

  // Rank per vector; fixed ranks sit below every programmable one
  genvar g;
  generate
    for (g = 0; g < epv_pkg::NUM_EXC; g++) begin : g_rank
      if (g == epv_pkg::VEC_NMI) begin : g_nmi
        assign rank[g] = epv_pkg::RANK_NMI;
      end else if (g == epv_pkg::VEC_HARD) begin : g_hard
        assign rank[g] = epv_pkg::RANK_HARD;
      end else begin : g_prog
        assign rank[g] = {1'b0, prio_r[g]} + epv_pkg::RANK_OFS;
      end
    end
  endgenerate

  // Winner among enabled pending exceptions
  epv_arbiter u_win (
    .cand_in   (pend_r & enable_eff),
    .rank_in   (rank),
    .found_out (win_found),
    .num_out   (win_num),
    .rank_out  (win_rank)
  );

  // Running priority is the most urgent active handler
  epv_arbiter u_run (
    .cand_in   (act_r),
    .rank_in   (rank),
    .found_out (run_found),
    .num_out   (run_num),
    .rank_out  (run_rank)
  );

  // Only strictly more urgent wins; equal rank stays pending
  assign offer   = win_found && (win_rank < run_rank);
  assign take_ok = take_in && req_r.valid;

  // Pending and active bookkeeping; set wins over clear
  always_comb begin
    take_hit = '0;
    ret_hit  = '0;
    if (take_ok) begin
      take_hit[req_r.num] = 1'b1;
    end
    if (return_in) begin
      ret_hit[return_num_in] = 1'b1;
    end
    pend_nxt = (pend_r & ~take_hit) | line_rise;
    act_nxt  = (act_r & ~ret_hit) | take_hit;
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      pend_r <= '0;
      act_r  <= '0;
    end else begin
      pend_r <= pend_nxt;
      act_r  <= act_nxt;
    end
  end

  // Offer sequencing toward the core
  always_comb begin
    state_nxt     = state_r;
    req_nxt       = req_r;
    req_nxt.valid = 1'b0;
    case (state_r)
      epv_pkg::ST_IDLE: begin
        if (offer) begin
          state_nxt = epv_pkg::ST_OFFER;
          req_nxt.valid = 1'b1;
          req_nxt.num   = win_num;
          req_nxt.addr  = {base_r[31:8], win_num, 2'b00};
        end
      end
      epv_pkg::ST_OFFER: begin
        if (take_ok) begin
          // One quiet cycle lets active state settle before re-arbitrating
          state_nxt = epv_pkg::ST_SETTLE;
        end else if (!offer) begin
          state_nxt = epv_pkg::ST_IDLE;
        end else begin
          // Late arrival replaces the offer in place
          req_nxt.valid = 1'b1;
          req_nxt.num   = win_num;
          req_nxt.addr  = {base_r[31:8], win_num, 2'b00};
        end
      end
      epv_pkg::ST_SETTLE: begin
        state_nxt = epv_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = epv_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= epv_pkg::ST_IDLE;
      req_r   <= '0;
    end else begin
      state_r <= state_nxt;
      req_r   <= req_nxt;
    end
  end

  // Registered views for the core
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      vector_base_out    <= epv_pkg::BASE_RESET;
      stack_addr_out     <= epv_pkg::BASE_RESET;
      reset_vec_addr_out <= {epv_pkg::BASE_RESET[31:8], epv_pkg::VEC_RESET, 2'b00};
      pending_out        <= '0;
      active_out         <= '0;
      running_rank_out   <= epv_pkg::RANK_IDLE;
    end else begin
      vector_base_out    <= base_r;
      stack_addr_out     <= {base_r[31:8], epv_pkg::VEC_STACK, 2'b00};
      reset_vec_addr_out <= {base_r[31:8], epv_pkg::VEC_RESET, 2'b00};
      pending_out        <= pend_r;
      active_out         <= act_r;
      running_rank_out   <= run_rank;
    end
  end

  assign request_out = req_r;

endmodule : epv_core
`default_nettype wire

// >>> core/epv_pkg.sv
package epv_pkg;

  localparam int          NUM_EXC      = 60;
  localparam int          NUM_W        = 6;
  localparam int          RANK_W       = 4;
  localparam int          PRIO_W       = 3;
  localparam int          IRQ_BASE     = 16;

  localparam logic [NUM_W-1:0]  VEC_STACK    = 6'h00;
  localparam logic [NUM_W-1:0]  VEC_RESET    = 6'h01;
  localparam logic [NUM_W-1:0]  VEC_NMI      = 6'h02;
  localparam logic [NUM_W-1:0]  VEC_HARD     = 6'h03;

  // Rank = priority + 3, so -3/-2/-1 map to 0/1/2
  localparam logic [RANK_W-1:0] RANK_NMI     = 4'h1;
  localparam logic [RANK_W-1:0] RANK_HARD    = 4'h2;
  localparam logic [RANK_W-1:0] RANK_OFS     = 4'h3;
  localparam logic [RANK_W-1:0] RANK_IDLE    = 4'hF;

  localparam logic [PRIO_W-1:0] PRIO_RESET   = 3'h0;

  localparam logic [31:0] BASE_RESET   = 32'h0000_0000;
  localparam logic [31:0] BASE_MIN     = 32'h0000_0100;
  localparam logic [31:0] BASE_MAX     = 32'h3FFF_FF00;
  localparam logic [31:0] BASE_ALIGN   = 32'h0000_00FF;

  // Vectors that exist: 2-6, 11, 12, 14, 15, 16-29, 34-54, 59
  localparam logic [NUM_EXC-1:0] VALID_MASK   = 60'h87F_FFFC_3FFF_D87C;
  localparam logic [NUM_EXC-1:0] FIXED_MASK   = 60'h000_0000_0000_000C;
  localparam logic [NUM_EXC-1:0] ENABLE_RESET = 60'h000_0000_0000_0000;

  typedef struct packed {
    logic              valid;
    logic [NUM_W-1:0]  num;
    logic [31:0]       addr;
  } epv_req_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_OFFER  = 3'b010,
    ST_SETTLE = 3'b100
  } epv_state_type;

endpackage : epv_pkg

// >>> core/epv_sync.sv
`timescale 1ns/10ps
`default_nettype none
module epv_sync (
  input  wire logic                       clock_in,
  input  wire logic                       reset_in,
  input  wire logic [epv_pkg::NUM_EXC-1:0] async_in,
  output logic      [epv_pkg::NUM_EXC-1:0] sync_out
);

  logic [epv_pkg::NUM_EXC-1:0] meta_r;

  // First stage feeds only the second stage
  genvar g;
  generate
    for (g = 0; g < epv_pkg::NUM_EXC; g++) begin : g_bit
      always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
          meta_r[g]   <= 1'b0;
          sync_out[g] <= 1'b0;
        end else begin
          meta_r[g]   <= async_in[g];
          sync_out[g] <= meta_r[g];
        end
      end
    end
  endgenerate

endmodule : epv_sync
`default_nettype wire

// >>> core/epv_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
module epv_arbiter (
  input  wire logic [epv_pkg::NUM_EXC-1:0]                       cand_in,
  input  wire logic [epv_pkg::NUM_EXC-1:0][epv_pkg::RANK_W-1:0]  rank_in,
  output logic                                                  found_out,
  output logic      [epv_pkg::NUM_W-1:0]                         num_out,
  output logic      [epv_pkg::RANK_W-1:0]                        rank_out
);

  always_comb begin
    found_out = 1'b0;
    num_out   = '0;
    rank_out  = epv_pkg::RANK_IDLE;
    // Ascending scan with strict compare keeps the lowest number on ties
    for (int i = 0; i < epv_pkg::NUM_EXC; i++) begin
      if (cand_in[i] && (rank_in[i] < rank_out)) begin
        found_out = 1'b1;
        num_out   = epv_pkg::NUM_W'(i);
        rank_out  = rank_in[i];
      end
    end
  end

endmodule : epv_arbiter
`default_nettype wire

// >>> tb/epv_chk.sv
`timescale 1ns/10ps
`default_nettype none
module epv_chk (
  input wire logic                        clock_in,
  input wire logic                        reset_in,
  input wire logic                        take_in,
  input wire epv_pkg::epv_req_type        request_out,
  input wire logic [31:0]                 vector_base_out,
  input wire logic [31:0]                 stack_addr_out,
  input wire logic [31:0]                 reset_vec_addr_out,
  input wire logic [epv_pkg::NUM_EXC-1:0] active_out,
  input wire logic [epv_pkg::RANK_W-1:0]  running_rank_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  property p_addr;
    request_out.valid |-> request_out.addr[7:0] == {request_out.num, 2'b00};
  endproperty
  a_addr: assert property (p_addr) else $error("vector offset wrong");
  property p_num;
    request_out.valid |-> epv_pkg::VALID_MASK[request_out.num] && request_out.num >= epv_pkg::VEC_NMI;
  endproperty
  a_num: assert property (p_num) else $error("offered vector does not exist");
  property p_stack;
    stack_addr_out == vector_base_out && reset_vec_addr_out == vector_base_out + 32'h0000_0004;
  endproperty
  a_stack: assert property (p_stack) else $error("stack or reset entry off base");
  property p_range;
    vector_base_out == 32'h0000_0000 || (vector_base_out[7:0] == 8'h00 &&
      vector_base_out >= epv_pkg::BASE_MIN && vector_base_out <= epv_pkg::BASE_MAX);
  endproperty
  a_range: assert property (p_range) else $error("base outside legal window");
  // Two edges back is the accept edge, so the taken vector is still named
  property p_take;
    (take_in && request_out.valid) |=> !request_out.valid ##1
      (!request_out.valid && active_out[$past(request_out.num, 2)]);
  endproperty
  a_take: assert property (p_take) else $error("accept did not activate");
  property p_nmi;
    running_rank_out == epv_pkg::RANK_NMI |-> !request_out.valid;
  endproperty
  a_nmi: assert property (p_nmi) else $error("offer while nmi runs");
  property p_hard;
    running_rank_out == epv_pkg::RANK_HARD && request_out.valid |-> request_out.num == epv_pkg::VEC_NMI;
  endproperty
  a_hard: assert property (p_hard) else $error("hard fault outranked");
  property p_rank;
    running_rank_out != 4'h0 && (running_rank_out <= 4'hA || running_rank_out == epv_pkg::RANK_IDLE);
  endproperty
  a_rank: assert property (p_rank) else $error("running rank out of range");
  property p_rst;
    $fell(reset_in) |-> vector_base_out == epv_pkg::BASE_RESET && running_rank_out == epv_pkg::RANK_IDLE;
  endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  c_offer: cover property (request_out.valid && take_in);
  c_nest: cover property (request_out.valid && running_rank_out != epv_pkg::RANK_IDLE);
  c_base: cover property ($changed(vector_base_out));
endmodule : epv_chk
bind epv_core epv_chk u_chk (.clock_in(clock_in), .reset_in(reset_in), .take_in(take_in),
  .request_out(request_out), .vector_base_out(vector_base_out), .stack_addr_out(stack_addr_out),
  .reset_vec_addr_out(reset_vec_addr_out), .active_out(active_out), .running_rank_out(running_rank_out));
`default_nettype wire

// >>> tb/epv_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module epv_cpu_model (
  input  wire logic                 clock_in,
  input  wire logic                 reset_in,
  input  wire epv_pkg::epv_req_type request_in,
  input  wire logic [3:0]           delay_in,
  output logic                      take_out
);
  logic [3:0] wait_r;
  // Accepts only a shown offer, after a programmable stall
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      take_out <= 1'b0;
      wait_r <= 4'h0;
    end else begin
      take_out <= 1'b0;
      wait_r <= 4'h0;
      if (request_in.valid && !take_out) begin
        if (wait_r >= delay_in)
          take_out <= 1'b1;
        else
          wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule : epv_cpu_model
`default_nettype wire

// >>> tb/tb_exception_priority_vector_logic.sv
`timescale 1ns/10ps
`default_nettype none
module tb_exception_priority_vector_logic;
  logic clock_in = '0, reset_in = '1, take_in, return_in = '0, prio_wr_in = '0, enable_wr_in = '0;
  logic enable_val_in = '0, base_wr_in = '0;
  logic [59:0] source_in = '0, pend, act;
  logic [5:0] return_num_in = '0, prio_num_in = '0, enable_num_in = '0;
  logic [2:0] prio_val_in = '0;
  logic [31:0] base_val_in = '0, base_exp = '0, nb, vbase, saddr, raddr;
  logic [3:0] dly = '0, rrank;
  logic [37:0] e;
  logic [37:0] exp_q[$];
  epv_pkg::epv_req_type req;
  int miscompares = 0, comparisons = 0, cyc = 0;
  epv_core uut (.clock_in(clock_in), .reset_in(reset_in), .source_in(source_in), .take_in(take_in),
    .return_in(return_in), .return_num_in(return_num_in), .prio_wr_in(prio_wr_in), .prio_num_in(prio_num_in),
    .prio_val_in(prio_val_in), .enable_wr_in(enable_wr_in), .enable_num_in(enable_num_in),
    .enable_val_in(enable_val_in), .base_wr_in(base_wr_in), .base_val_in(base_val_in), .request_out(req),
    .vector_base_out(vbase), .stack_addr_out(saddr), .reset_vec_addr_out(raddr), .pending_out(pend),
    .active_out(act), .running_rank_out(rrank));
  epv_cpu_model cpu (.clock_in(clock_in), .reset_in(reset_in), .request_in(req), .delay_in(dly),
    .take_out(take_in));
  always #25 clock_in = ~clock_in;
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      stop_test();
    end else if (take_in === 1'b1 && req.valid === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 38'h0;
      check("offer", {req.num, req.addr}, e);
    end
  end
  function automatic logic [59:0] bm(input int v);
    bm = '0;
    bm[v] = 1'b1;
  endfunction : bm
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tick
  task automatic cfg(input int v, input int p, input logic wp);
    @(posedge clock_in);
    prio_wr_in <= wp;
    prio_num_in <= 6'(v);
    prio_val_in <= 3'(p);
    enable_wr_in <= 1'b1;
    enable_num_in <= 6'(v);
    enable_val_in <= 1'b1;
    @(posedge clock_in);
    prio_wr_in <= 1'b0;
    enable_wr_in <= 1'b0;
  endtask : cfg
  task automatic fire(input logic [59:0] m);
    @(posedge clock_in);
    source_in <= m;
    dly <= 4'($urandom_range(3, 0));
    tick(4);
    source_in <= '0;
  endtask : fire
  task automatic want(input int v);
    exp_q.push_back({6'(v), base_exp + 32'(v * 4)});
  endtask : want
  task automatic hold(input int v);
    tick(8);
    check("held", {pend[v], act[v]}, 2'b10);
  endtask : hold
  task automatic serve(input int v);
    for (int i = 0; i < 100 && act[v] !== 1'b1; i++) @(posedge clock_in);
    check("active", act[v], 1'b1);
    @(posedge clock_in);
    return_in <= 1'b1;
    return_num_in <= 6'(v);
    @(posedge clock_in);
    return_in <= 1'b0;
    tick(3);
    check("retired", act[v], 1'b0);
  endtask : serve
  task automatic wrbase(input logic [31:0] b);
    @(posedge clock_in);
    base_wr_in <= 1'b1;
    base_val_in <= b;
    @(posedge clock_in);
    base_wr_in <= 1'b0;
  endtask : wrbase
  initial begin
    void'($urandom(14715));
    tick(12);
    reset_in <= 1'b0;
    tick(1);
    check("reset state", {vbase, rrank, pend == 60'h0}, {32'h0000_0000, 4'hF, 1'b1});
    check("entries", {saddr, raddr}, {32'h0000_0000, 32'h0000_0004});
    $display("test reset done");
    cfg(16, 0, 1'b1);
    want(16);
    fire(bm(16));
    serve(16);
    cfg(27, 0, 1'b0);
    cfg(26, 1, 1'b1);
    want(27);
    want(26);
    fire(bm(26) | bm(27));
    serve(27);
    serve(26);
    $display("test default priority done");
    nb = 32'($urandom_range(7, 0));
    cfg(17, nb, 1'b1);
    cfg(18, nb, 1'b1);
    want(17);
    want(18);
    fire(bm(17) | bm(18));
    hold(18);
    check("running rank", rrank, 64'(nb + 32'h0000_0003));
    serve(17);
    serve(18);
    $display("test tie done");
    cfg(20, 7, 1'b1);
    cfg(21, $urandom_range(6, 0), 1'b1);
    want(21);
    want(20);
    fire(bm(20) | bm(21));
    hold(20);
    serve(21);
    serve(20);
    $display("test priority order done");
    cfg(22, 4, 1'b1);
    cfg(23, 1, 1'b1);
    want(22);
    want(23);
    fire(bm(22));
    tick(10);
    fire(bm(23));
    serve(23);
    serve(22);
    $display("test preempt done");
    want(2);
    want(3);
    want(16);
    fire(bm(2) | bm(3) | bm(16));
    hold(3);
    serve(2);
    serve(3);
    serve(16);
    $display("test fixed priorities done");
    fire(bm(24));
    hold(24);
    want(24);
    cfg(24, 3, 1'b1);
    serve(24);
    fire(bm(30) | bm(7) | bm(57));
    tick(4);
    check("reserved", pend, 60'h0);
    $display("test enable and reserved done");
    for (int i = 0; i < 2; i++) begin
      nb = i ? 32'($urandom_range(32'h003F_FFFF, 32'h0000_0001)) << 8 : epv_pkg::BASE_MAX;
      wrbase(nb);
      tick(3);
      check("base", {vbase, raddr}, {nb, nb + 32'h0000_0004});
      check("base stack", saddr, nb);
      base_exp = nb;
    end
    wrbase(nb + 32'h0000_0080);
    wrbase(32'h4000_0000);
    wrbase(32'h0000_0000);
    tick(3);
    check("refused base", vbase, base_exp);
    cfg(59, 2, 1'b1);
    want(59);
    fire(bm(59));
    serve(59);
    $display("test relocation done");
    tick(5);
    check("leftover", exp_q.size(), 64'h0);
    stop_test();
  end
endmodule : tb_exception_priority_vector_logic
`default_nettype wire
